// ==== rtl/dtcms_top.sv ====
`default_nettype none
`include "dtcms_cfg.svh"

module dtcms_top (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic high_freq_clock_i,
    input wire logic low_freq_clock_i,
    input wire logic lower_event_pin_i,
    input wire logic upper_event_pin_i,
    output logic lower_match_irq_o,
    output logic upper_match_irq_o,
    output logic lower_divider_output_n_o,
    output logic upper_divider_output_n_o
);
    import dtcms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic tap_hit(input logic [`DTCMS_PRE_W-1:0] pre, input int k);
        logic r;
        r = 1'b1;
        for (int b = 0; b < `DTCMS_PRE_W; b++) begin
            if (b < k && !pre[b]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction : tap_hit

    function automatic dtcms_kind_e kind_of(input dtcms_mode_e m);
        dtcms_kind_e k;
        case (m)
            DTCMS_M_DIV8: k = DTCMS_K_DIV;
            DTCMS_M_PWM8, DTCMS_M_PWM16: k = DTCMS_K_PWM;
            DTCMS_M_PPG16: k = DTCMS_K_PPG;
            default: k = DTCMS_K_TMR;
        endcase
        return k;
    endfunction : kind_of

    function automatic dtcms_step_s step(input dtcms_kind_e k, input logic [15:0] cnt, input logic [15:0] cmp,
                                         input logic [15:0] duty, input logic tff, input logic wide);
        logic [15:0] nxt;
        logic [15:0] top;
        dtcms_step_s r;
        nxt = cnt + 16'h0001;
        top = wide ? 16'hffff : 16'h00ff;
        r.cnt = nxt & top;
        r.tff = tff;
        r.irq = 1'b0;
        case (k)
            DTCMS_K_PWM: begin
                if (cnt == top) begin
                    r.cnt = 16'h0000;
                    r.tff = ~tff;
                    r.irq = 1'b1;
                end else if (nxt == duty) begin
                    r.tff = ~tff;
                end
            end
            DTCMS_K_PPG: begin
                if (nxt == cmp) begin
                    r.cnt = 16'h0000;
                    r.tff = ~tff;
                    r.irq = 1'b1;
                end else if (nxt == duty) begin
                    r.tff = ~tff;
                end
            end
            default: begin
                if (nxt == cmp) begin
                    r.cnt = 16'h0000;
                    r.irq = 1'b1;
                    if (k == DTCMS_K_DIV) begin
                        r.tff = ~tff;
                    end
                end
            end
        endcase
        return r;
    endfunction : step

    ////////////////////////////////////////////////////////////////////////////
    // Source clocks
    dtcms_state_s q;
    dtcms_state_s d;
    dtcms_clk_if lo_if();
    dtcms_clk_if hi_if();
    logic sixteen;
    dtcms_mode_e mode_hi;
    dtcms_mode_e mode_lo;
    logic [1:0] ev_fall;
    logic fs8;
    dtcms_src_t src_base;
    logic [7:0] badr;
    logic bus_req;
    dtcms_step_s st;

    assign sixteen = q.ctl[1][`DTCMS_CTL_MODE_HI];
    assign mode_hi = dtcms_mode_e'(q.ctl[1][`DTCMS_CTL_MODE_HI:`DTCMS_CTL_MODE_LO]);
    assign mode_lo = sixteen ? mode_hi : dtcms_mode_e'(q.ctl[0][`DTCMS_CTL_MODE_HI:`DTCMS_CTL_MODE_LO]);
    assign ev_fall = q.ev_prev & ~{upper_event_pin_i, lower_event_pin_i};
    assign fs8 = low_freq_clock_i & (q.lfp == 3'h7);
    assign src_base = {fs8, 1'b0, high_freq_clock_i, high_freq_clock_i & tap_hit(q.pre, 1), low_freq_clock_i,
                       high_freq_clock_i & tap_hit(q.pre, 3), high_freq_clock_i & tap_hit(q.pre, 5),
                       high_freq_clock_i & tap_hit(q.pre, 7), high_freq_clock_i & tap_hit(q.pre, 11)};

    assign lo_if.mode = mode_lo;
    assign lo_if.code = q.ctl[0][`DTCMS_CTL_CK_HI:`DTCMS_CTL_CK_LO];
    assign lo_if.slow = q.sys[`DTCMS_SYS_SLOW];
    assign lo_if.tap = q.sys[`DTCMS_SYS_TAP];
    // lower pin feeds 8-bit and 16-bit event
    assign lo_if.src = src_base | {1'b0, ev_fall[0], 7'h00};
    assign hi_if.mode = mode_hi;
    assign hi_if.code = q.ctl[1][`DTCMS_CTL_CK_HI:`DTCMS_CTL_CK_LO];
    assign hi_if.slow = q.sys[`DTCMS_SYS_SLOW];
    assign hi_if.tap = q.sys[`DTCMS_SYS_TAP];
    assign hi_if.src = src_base | {1'b0, ev_fall[1], 7'h00};

    dtcms_clk_sel u_sel_lo (
        .cs(lo_if.selector)
    );

    dtcms_clk_sel u_sel_hi (
        .cs(hi_if.selector)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    assign badr = {wb_adr_i[7:2], 2'b00};
    assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;

    always_comb begin
        d = q;
        st = '0;
        if (ce_i) begin
            d.ack = 1'b0;
            d.irq = 2'b00;
            d.ev_prev = {upper_event_pin_i, lower_event_pin_i};
            if (high_freq_clock_i) begin
                d.pre = q.pre + 11'h001;
            end
            if (low_freq_clock_i) begin
                d.lfp = q.lfp + 3'h1;
            end
            // 8-bit channels, then 16-bit cascaded pair
            for (int i = 0; i < 2; i++) begin
                if (sixteen || !q.ctl[i][`DTCMS_CTL_START] || (i == 0 && mode_lo == DTCMS_M_RSVD)) begin
                    if (!sixteen) begin
                        d.cnt[i] = 8'h00;
                        d.out_n[i] = ~q.ctl[i][`DTCMS_CTL_TFF];
                        d.dact[i] = q.dc[i];
                    end
                end else if ((i == 0) ? lo_if.tick : hi_if.tick) begin
                    st = step(kind_of((i == 0) ? mode_lo : mode_hi), {8'h00, q.cnt[i]}, {8'h00, q.tc[i]},
                              {8'h00, q.dact[i]}, ~q.out_n[i], 1'b0);
                    d.cnt[i] = st.cnt[7:0];
                    d.out_n[i] = ~st.tff;
                    d.irq[i] = st.irq;
                    if (st.irq) begin
                        d.dact[i] = q.dc[i];
                    end
                end
            end
            if (sixteen) begin
                if (!q.ctl[1][`DTCMS_CTL_START]) begin
                    d.cnt = '0;
                    d.out_n[1] = ~q.ctl[1][`DTCMS_CTL_TFF];
                    d.dact = q.dc;
                end else if (lo_if.tick) begin
                    st = step(kind_of(mode_hi), {q.cnt[1], q.cnt[0]}, {q.tc[1], q.tc[0]}, {q.dact[1], q.dact[0]},
                              ~q.out_n[1], 1'b1);
                    d.cnt[1] = st.cnt[15:8];
                    d.cnt[0] = st.cnt[7:0];
                    d.out_n[1] = ~st.tff;
                    d.irq[1] = st.irq;
                    if (st.irq) begin
                        d.dact = q.dc;
                    end
                end
            end
            // Register bus
            if (bus_req) begin
                d.ack = 1'b1;
                case (badr)
                    `DTCMS_OFF_CTL_LO: d.rdat = {24'h00_0000, q.ctl[0]};
                    `DTCMS_OFF_CTL_HI: d.rdat = {24'h00_0000, q.ctl[1]};
                    `DTCMS_OFF_TC_LO: d.rdat = {24'h00_0000, q.tc[0]};
                    `DTCMS_OFF_TC_HI: d.rdat = {24'h00_0000, q.tc[1]};
                    `DTCMS_OFF_DC_LO: d.rdat = {24'h00_0000, q.dc[0]};
                    `DTCMS_OFF_DC_HI: d.rdat = {24'h00_0000, q.dc[1]};
                    `DTCMS_OFF_SYS: d.rdat = {30'h0000_0000, q.sys};
                    `DTCMS_OFF_STAT: d.rdat = {8'h00, q.cnt[1], q.cnt[0], 6'h00, hi_if.legal, lo_if.legal};
                    default: d.rdat = 32'h0000_0000;
                endcase
                if (wb_we_i && wb_sel_i[0]) begin
                    case (badr)
                        `DTCMS_OFF_CTL_LO: d.ctl[0] = wb_dat_i[7:0];
                        `DTCMS_OFF_CTL_HI: d.ctl[1] = wb_dat_i[7:0];
                        `DTCMS_OFF_TC_LO: d.tc[0] = wb_dat_i[7:0];
                        `DTCMS_OFF_TC_HI: d.tc[1] = wb_dat_i[7:0];
                        `DTCMS_OFF_DC_LO: d.dc[0] = wb_dat_i[7:0];
                        `DTCMS_OFF_DC_HI: d.dc[1] = wb_dat_i[7:0];
                        `DTCMS_OFF_SYS: d.sys = wb_dat_i[1:0];
                        default: d.sys = q.sys;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.out_n <= `DTCMS_RST_OUT_N;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign lower_match_irq_o = q.irq[0];
    assign upper_match_irq_o = q.irq[1];
    assign lower_divider_output_n_o = q.out_n[0];
    assign upper_divider_output_n_o = q.out_n[1];

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    logic lo_tmr_run;
    assign lo_tmr_run = !sixteen && q.ctl[0][`DTCMS_CTL_START] && mode_lo == DTCMS_M_TMR8;

    chk_irq_one_cycle: assert property (lower_match_irq_o && ce_i |=> !lower_match_irq_o)
        else $error("lower match request wider than one clock");
    chk_match_clear_irq: assert property (lo_tmr_run && ce_i && lo_if.tick && (q.cnt[0] + 8'h01) == q.tc[0]
        |=> q.cnt[0] == 8'h00 && lower_match_irq_o)
        else $error("match did not clear counter and request");
    chk_count_advance: assert property (lo_tmr_run && ce_i && lo_if.tick && (q.cnt[0] + 8'h01) != q.tc[0]
        |=> q.cnt[0] == $past(q.cnt[0]) + 8'h01 && !lower_match_irq_o)
        else $error("counter did not advance by one");
    chk_compare_live: assert property (bus_req && ce_i && wb_we_i && wb_sel_i[0] && badr == `DTCMS_OFF_TC_LO
        |=> q.tc[0] == $past(wb_dat_i[7:0]))
        else $error("compare write not in effect next clock");
    chk_upper_carry: assert property (sixteen && mode_hi == DTCMS_M_TMR16 && q.ctl[1][`DTCMS_CTL_START] && ce_i
        && lo_if.tick && q.cnt[0] == 8'hff && ({q.cnt[1], q.cnt[0]} + 16'h0001) != {q.tc[1], q.tc[0]}
        |=> q.cnt[1] == $past(q.cnt[1]) + 8'h01 && q.cnt[0] == 8'h00)
        else $error("upper byte missed lower overflow");
    chk_illegal_blocked: assert property ((mode_lo == DTCMS_M_TMR8 || mode_lo == DTCMS_M_DIV8)
        && lo_if.code inside {3'h4, 3'h5, 3'h6} |-> !lo_if.tick)
        else $error("illegal source produced a tick");
    chk_warmup_source: assert property (sixteen && mode_hi == DTCMS_M_WARM && lo_if.tick
        |-> lo_if.code == (q.sys[`DTCMS_SYS_SLOW] ? `DTCMS_CODE_FC : `DTCMS_CODE_FS))
        else $error("warm-up counter on wrong source");
    chk_event_source: assert property (lo_if.tick && lo_if.code == `DTCMS_CODE_EVENT |-> ev_fall[0])
        else $error("event count without lower pin edge");
    chk_pwm8_fast: assert property (mode_lo == DTCMS_M_PWM8 && !q.sys[`DTCMS_SYS_SLOW]
        |-> lo_if.legal == (lo_if.code != `DTCMS_CODE_EVENT))
        else $error("8-bit PWM source legality wrong");
    chk_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("bus acknowledge held over two clocks");

    cov_lower_match: cover property (lo_tmr_run && lower_match_irq_o);
    cov_sixteen_match: cover property (sixteen && upper_match_irq_o);
    cov_pwm_toggle: cover property (mode_lo == DTCMS_M_PWM8 && $changed(lower_divider_output_n_o));
    cov_illegal_src: cover property (q.ctl[0][`DTCMS_CTL_START] && !lo_if.legal);

endmodule : dtcms_top

`default_nettype wire

// ==== shared/dtcms_cfg.svh ====
`ifndef DTCMS_CFG_SVH
`define DTCMS_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define DTCMS_OFF_CTL_LO 8'h00
`define DTCMS_OFF_CTL_HI 8'h04
`define DTCMS_OFF_TC_LO 8'h08
`define DTCMS_OFF_TC_HI 8'h0c
`define DTCMS_OFF_DC_LO 8'h10
`define DTCMS_OFF_DC_HI 8'h14
`define DTCMS_OFF_SYS 8'h18
`define DTCMS_OFF_STAT 8'h1c

////////////////////////////////////////////////////////////////////////////////
// Control field positions
`define DTCMS_CTL_TFF 7
`define DTCMS_CTL_CK_HI 6
`define DTCMS_CTL_CK_LO 4
`define DTCMS_CTL_START 3
`define DTCMS_CTL_MODE_HI 2
`define DTCMS_CTL_MODE_LO 0
`define DTCMS_SYS_SLOW 0
`define DTCMS_SYS_TAP 1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define DTCMS_RST_BYTE 8'h00
`define DTCMS_RST_SYS 2'h0
`define DTCMS_RST_OUT_N 2'h3

////////////////////////////////////////////////////////////////////////////////
// Prescaler widths and source indices
`define DTCMS_PRE_W 11
`define DTCMS_LFP_W 3
`define DTCMS_SRC_W 9
`define DTCMS_SRC_FS8 8
`define DTCMS_CODE_EVENT 3'h7
`define DTCMS_CODE_FS 3'h4
`define DTCMS_CODE_FC 3'h6

////////////////////////////////////////////////////////////////////////////////
// Legal source masks, bit n for clock code n
`define DTCMS_FAST_TMR8 8'h8f
`define DTCMS_FAST_DIV8 8'h0f
`define DTCMS_FAST_PWM8 8'h7f
`define DTCMS_FAST_TMR16 8'h8f
`define DTCMS_FAST_WARM 8'h10
`define DTCMS_FAST_PWM16 8'hff
`define DTCMS_FAST_PPG16 8'h8f
`define DTCMS_SLOW_TMR8 8'h81
`define DTCMS_SLOW_DIV8 8'h01
`define DTCMS_SLOW_PWM8 8'h11
`define DTCMS_SLOW_TMR16 8'h81
`define DTCMS_SLOW_WARM 8'h40
`define DTCMS_SLOW_PWM16 8'h91
`define DTCMS_SLOW_PPG16 8'h81
`define DTCMS_MASK_NONE 8'h00

`endif

// ==== shared/dtcms_pkg.sv ====
`default_nettype none
`include "dtcms_cfg.svh"

package dtcms_pkg;

    typedef enum logic [2:0] {
        DTCMS_M_TMR8 = 3'b000,
        DTCMS_M_DIV8 = 3'b001,
        DTCMS_M_PWM8 = 3'b010,
        DTCMS_M_RSVD = 3'b011,
        DTCMS_M_TMR16 = 3'b100,
        DTCMS_M_WARM = 3'b101,
        DTCMS_M_PWM16 = 3'b110,
        DTCMS_M_PPG16 = 3'b111
    } dtcms_mode_e;

    typedef enum logic [1:0] {
        DTCMS_K_TMR = 2'b00,
        DTCMS_K_DIV = 2'b01,
        DTCMS_K_PWM = 2'b10,
        DTCMS_K_PPG = 2'b11
    } dtcms_kind_e;

    typedef logic [2:0] dtcms_code_t;
    typedef logic [`DTCMS_SRC_W-1:0] dtcms_src_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic tff;
        logic irq;
    } dtcms_step_s;

    typedef struct packed {
        logic [1:0][7:0] ctl;
        logic [1:0][7:0] tc;
        logic [1:0][7:0] dc;
        logic [1:0][7:0] dact;
        logic [1:0][7:0] cnt;
        logic [1:0] sys;
        logic [`DTCMS_PRE_W-1:0] pre;
        logic [`DTCMS_LFP_W-1:0] lfp;
        logic [1:0] ev_prev;
        logic [1:0] out_n;
        logic [1:0] irq;
        logic ack;
        logic [31:0] rdat;
    } dtcms_state_s;

endpackage : dtcms_pkg

`default_nettype wire

// ==== shared/dtcms_clk_if.sv ====
`default_nettype none

interface dtcms_clk_if;
    dtcms_pkg::dtcms_mode_e mode;
    dtcms_pkg::dtcms_code_t code;
    logic slow;
    logic tap;
    dtcms_pkg::dtcms_src_t src;
    logic tick;
    logic legal;

    modport selector(input mode, input code, input slow, input tap, input src, output tick, output legal);
    modport user(output mode, output code, output slow, output tap, output src, input tick, input legal);
endinterface : dtcms_clk_if

`default_nettype wire

// ==== rtl/dtcms_clk_sel.sv ====
`default_nettype none
`include "dtcms_cfg.svh"

module dtcms_clk_sel (
    dtcms_clk_if.selector cs
);
    import dtcms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Legal source table per mode
    function automatic logic [7:0] legal_mask(input dtcms_mode_e m, input logic slow);
        logic [7:0] r;
        r = `DTCMS_MASK_NONE;
        case (m)
            DTCMS_M_TMR8: r = slow ? `DTCMS_SLOW_TMR8 : `DTCMS_FAST_TMR8;
            DTCMS_M_DIV8: r = slow ? `DTCMS_SLOW_DIV8 : `DTCMS_FAST_DIV8;
            DTCMS_M_PWM8: r = slow ? `DTCMS_SLOW_PWM8 : `DTCMS_FAST_PWM8;
            DTCMS_M_TMR16: r = slow ? `DTCMS_SLOW_TMR16 : `DTCMS_FAST_TMR16;
            DTCMS_M_WARM: r = slow ? `DTCMS_SLOW_WARM : `DTCMS_FAST_WARM;
            DTCMS_M_PWM16: r = slow ? `DTCMS_SLOW_PWM16 : `DTCMS_FAST_PWM16;
            DTCMS_M_PPG16: r = slow ? `DTCMS_SLOW_PPG16 : `DTCMS_FAST_PPG16;
            default: r = `DTCMS_MASK_NONE;
        endcase
        return r;
    endfunction : legal_mask

    logic raw;
    logic [7:0] mask;

    always_comb begin
        if (cs.code == 3'h0) begin
            raw = (cs.slow | cs.tap) ? cs.src[`DTCMS_SRC_FS8] : cs.src[0];
        end else begin
            raw = cs.src[cs.code];
        end
    end

    assign mask = legal_mask(cs.mode, cs.slow);
    assign cs.legal = mask[cs.code];
    assign cs.tick = raw & cs.legal;

endmodule : dtcms_clk_sel

`default_nettype wire

// ==== verif/test_dual_timer_clock_mode_select.sv ====
`default_nettype none
`include "dtcms_cfg.svh"

module test_dual_timer_clock_mode_select;
    import dtcms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [31:0] val; logic [31:0] msk;} dtcms_exp_s;
    logic sys_clk_i, reset_n_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o;
    logic hf, lf, fc_steady;
    logic [1:0] ev;
    wire logic [1:0] irq;
    wire logic [1:0] div_n;
    logic [1:0] prev_irq = 2'h0;
    dtcms_exp_s rd_q[$];
    int per_q[2][$];
    int last_irq[2];
    int error_cnt = 0;
    int n_checks = 0;
    int cyc_n = 0;

    dtcms_top dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .high_freq_clock_i(hf),
        .low_freq_clock_i(lf), .lower_event_pin_i(ev[0]), .upper_event_pin_i(ev[1]),
        .lower_match_irq_o(irq[0]), .upper_match_irq_o(irq[1]),
        .lower_divider_output_n_o(div_n[0]), .upper_divider_output_n_o(div_n[1]));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and reference ticks
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        hf <= fc_steady ? 1'b1 : 1'($urandom);
        lf <= 1'($urandom);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : check

    task automatic final_report();
        $display("Checks: %0d, errors: %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'h1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) check(1'b0, "bus cycle not acknowledged");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        rd_q.push_back('{v, m});
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wait_irq(input int ch, input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge sys_clk_i);
                k++;
            end while (irq[ch] !== 1'b1 && k < 5000);
            if (k >= 5000) check(1'b0, "no match interrupt");
        end
    endtask : wait_irq

    task automatic pushq(input int ch, input int first, input int p, input int n);
        per_q[ch].push_back(first);
        repeat (n) per_q[ch].push_back(p);
    endtask : pushq

    task automatic fall(input int ch);
        @(posedge sys_clk_i);
        ev[ch] <= 1'b0;
        @(posedge sys_clk_i);
        ev[ch] <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
    endtask : fall

    function automatic logic [7:0] legal_mask(input int s, input int m);
        case ({s[0], m[1:0]})
            3'b000: return `DTCMS_FAST_TMR8;
            3'b001: return `DTCMS_FAST_DIV8;
            3'b010: return `DTCMS_FAST_PWM8;
            3'b100: return `DTCMS_SLOW_TMR8;
            3'b101: return `DTCMS_SLOW_DIV8;
            default: return `DTCMS_SLOW_PWM8;
        endcase
    endfunction : legal_mask

    ////////////////////////////////////////////////////////////////////////////
    // Output monitor
    always @(posedge sys_clk_i) begin
        dtcms_exp_s e;
        int p;
        cyc_n++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
            e = rd_q.pop_front();
            check((wb_dat_o & e.msk) === e.val, "read data mismatch");
        end
        for (int c = 0; c < 2; c++) begin
            if (irq[c] === 1'b1) begin
                check(prev_irq[c] !== 1'b1, "interrupt wider than one cycle");
                if (per_q[c].size() > 0) begin
                    p = per_q[c].pop_front();
                    if (p > 0) check(cyc_n - last_irq[c] == p, "interrupt period mismatch");
                end
                last_irq[c] = cyc_n;
            end
        end
        prev_irq <= irq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        int c;
        logic v0;
        void'($urandom(32'h4541));
        {wb_cyc_i, wb_stb_i, wb_we_i, ce_i} = 4'h1;
        {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        fc_steady = 1'b0;
        ev = 2'h3;
        reset_n_i = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 8'h1c; a += 4) rd(8'(a), 32'h0000_0000, 32'hffff_ffff);
        rd(`DTCMS_OFF_STAT, 32'h0000_0003, 32'hffff_ffff);
        wr(`DTCMS_OFF_STAT, 32'hffff_ffff);
        rd(`DTCMS_OFF_STAT, 32'h0000_0003, 32'hffff_ffff);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0000_0000, 32'hffff_ffff);
        for (int s = 0; s < 2; s++) begin
            wr(`DTCMS_OFF_SYS, 32'(s));
            for (int m = 0; m < 3; m++) begin
                for (int k = 0; k < 8; k++) begin
                    wr(`DTCMS_OFF_CTL_LO, 32'({k[2:0], 1'b0, m[2:0]}));
                    rd(`DTCMS_OFF_STAT, 32'(legal_mask(s, m) >> k) & 32'h1, 32'h1);
                end
            end
        end
        wr(`DTCMS_OFF_SYS, 32'h0000_0000);
        fc_steady <= 1'b1;
        c = 5 + ($urandom % 8);
        pushq(0, 0, 8 * c, 2);
        wr(`DTCMS_OFF_TC_LO, 32'(c));
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0038);
        wait_irq(0, 3);
        pushq(0, 160, 160, 1);
        wr(`DTCMS_OFF_TC_LO, 32'h0000_0014);
        wait_irq(0, 2);
        pushq(0, 64, 64, 1);
        wr(`DTCMS_OFF_TC_LO, 32'h0000_0008);
        wait_irq(0, 2);
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0033);
        wr(`DTCMS_OFF_TC_LO, 32'h0000_0002);
        wr(`DTCMS_OFF_TC_HI, 32'h0000_0001);
        pushq(1, 0, 2064, 1);
        wr(`DTCMS_OFF_CTL_HI, 32'h0000_000c);
        wait_irq(1, 2);
        wr(`DTCMS_OFF_CTL_HI, 32'h0000_0000);
        wr(`DTCMS_OFF_TC_LO, 32'h0000_0005);
        pushq(0, 0, 40, 1);
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0039);
        wait_irq(0, 1);
        v0 = div_n[0];
        wait_irq(0, 1);
        check(div_n[0] !== v0, "divider output did not toggle");
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0081);
        repeat (2) @(posedge sys_clk_i);
        check(div_n[0] === 1'b0, "stopped output not inverse of control");
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0001);
        repeat (2) @(posedge sys_clk_i);
        check(div_n[0] === 1'b1, "stopped output not inverse of control");
        wr(`DTCMS_OFF_DC_LO, 32'h0000_0040);
        pushq(0, 0, 256, 1);
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_006a);
        wait_irq(0, 2);
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0033);
        wr(`DTCMS_OFF_TC_LO, 32'h0000_0014);
        wr(`DTCMS_OFF_TC_HI, 32'h0000_0000);
        wr(`DTCMS_OFF_DC_LO, 32'h0000_0005);
        pushq(1, 0, 160, 1);
        wr(`DTCMS_OFF_CTL_HI, 32'h0000_000f);
        wait_irq(1, 2);
        wr(`DTCMS_OFF_CTL_HI, 32'h0000_0000);
        fc_steady <= 1'b0;
        wr(`DTCMS_OFF_TC_LO, 32'h0000_0003);
        wr(`DTCMS_OFF_TC_HI, 32'h0000_0003);
        wr(`DTCMS_OFF_CTL_LO, 32'h0000_0078);
        wr(`DTCMS_OFF_CTL_HI, 32'h0000_0078);
        repeat (2) fall(0);
        fall(1);
        rd(`DTCMS_OFF_STAT, 32'h0001_0200, 32'h00ff_ff00);
        // Clock enable low hides this edge
        ce_i <= 1'b0;
        fall(0);
        ce_i <= 1'b1;
        fall(0);
        fall(1);
        rd(`DTCMS_OFF_STAT, 32'h0002_0000, 32'h00ff_ff00);
        wr(`DTCMS_OFF_CTL_HI, 32'h0000_0070);
        rd(`DTCMS_OFF_STAT, 32'h0000_0000, 32'h00ff_0000);
        repeat (4) @(posedge sys_clk_i);
        final_report();
    end

    initial begin
        #(40 * 40000);
        error_cnt++;
        final_report();
    end

endmodule : test_dual_timer_clock_mode_select

`default_nettype wire
